//--- pkg/mcr_regs.svh
// Register indices, field positions, reset values and bus constants of the meter control block
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH

`define MCR_ADDR_W 12
`define MCR_IDX_DEADBAND 8'hE5
`define MCR_IDX_TIMEBASE 8'hE9
`define MCR_IDX_MUX_POS 8'hF0
`define MCR_IDX_MUX_NEG 8'hF1
`define MCR_IDX_STATUS 8'hF2
`define MCR_ADDR_OF(idx) {2'h0, idx, 2'h0}

`define MCR_RST_DEADBAND 8'h00
`define MCR_RST_TIMEBASE 8'h07
`define MCR_RST_MUX 5'h00

`define MCR_PRE_LSB 0
`define MCR_PRE_MSB 2
`define MCR_DIV_LSB 3
`define MCR_DIV_MSB 7
`define MCR_PRE_INTERNAL 3'h7

`define MCR_RESP_OKAY 2'h0
`define MCR_RESP_SLVERR 2'h2

`endif

//--- pkg/mcr_pkg.sv
// Types shared by the meter control block
package mcr_pkg;

   typedef struct packed {
      logic signed [47:0] charge2;
      logic signed [47:0] energy2;
      logic signed [47:0] charge3;
      logic signed [47:0] energy4;
   } mcr_accum_t;

   typedef struct packed {
      mcr_accum_t high;
      mcr_accum_t low;
   } mcr_thresh_t;

   typedef struct packed {
      logic signed [19:0] current;
      logic signed [31:0] power;
   } mcr_sample_t;

   typedef enum logic [4:0] {
      MCR_SRC_NONE = 5'b00000,
      MCR_SRC_GEN_FIRST = 5'b00001,
      MCR_SRC_GEN_LAST = 5'b01100,
      MCR_SRC_NEG_TEST = 5'b01101,
      MCR_SRC_POS_TEST = 5'b01110,
      MCR_SRC_BAT_NEG = 5'b01111,
      MCR_SRC_BAT_POS = 5'b10000,
      MCR_SRC_CF2_NEG = 5'b10001,
      MCR_SRC_CF2_POS = 5'b10010,
      MCR_SRC_CF1_NEG = 5'b10011,
      MCR_SRC_CF1_POS = 5'b10100,
      MCR_SRC_RSVD_21 = 5'b10101,
      MCR_SRC_SECOND_REFERENCE_VOLTAGE = 5'b10110,
      MCR_SRC_SECOND_REFERENCE_VOLTAGE_250K = 5'b10111
   } mcr_mux_code_t;

   typedef struct packed {
      logic [11:0] general;
      logic neg_test_node;
      logic pos_test_node;
      logic battery_negative;
      logic battery_positive;
      logic cap_two_negative;
      logic cap_two_positive;
      logic cap_one_negative;
      logic cap_one_positive;
      logic second_reference_voltage_direct;
      logic second_reference_voltage_250k;
   } mcr_mux_conn_t;

endpackage

//--- logic/mcr_top.sv
// Meter control registers: dead band gated accumulation, timebase control, mux select decode
//
// Behaviour
// - Magnitude at dead band or above accumulates samples
// - Compare updated accumulators with thresholds right after
// - Below dead band, second accumulators stay unchanged
// - Dead band compared in current sample units
// - Prescaler all ones selects internal clock, reset 0x07
// - Prescaler bits 2:0, divider 7:3, divider resets zero
// - Independent five-bit select for each mux output
// - Codes 10111/10110 select second reference paths
// - Code 01110 selects positive current test node
// - Code 01101 selects negative current test node
`timescale 1ns/1ps
`include "mcr_regs.svh"

module mcr_top (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // AXI4-Lite write address
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [`MCR_ADDR_W-1:0] s_axi_awaddr_in,
   // AXI4-Lite write data
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   // AXI4-Lite write response
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   output logic [1:0] s_axi_bresp_out,
   // AXI4-Lite read address
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   input wire logic [`MCR_ADDR_W-1:0] s_axi_araddr_in,
   // AXI4-Lite read data
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   // Second channel samples
   input wire logic sample_valid_in,
   input wire mcr_pkg::mcr_sample_t second_sample_in,
   // Threshold settings
   input wire mcr_pkg::mcr_thresh_t thresholds_in,
   // Accumulators and threshold results
   output mcr_pkg::mcr_accum_t accumulators_out,
   output logic compare_done_out,
   output logic [3:0] above_high_out,
   output logic [3:0] below_low_out,
   // Timebase
   output logic internal_clock_select_out,
   output logic [2:0] prescaler_out,
   output logic [4:0] divider_out,
   // Multiplexer
   output logic [4:0] positive_mux_select_out,
   output logic [4:0] negative_mux_select_out,
   output mcr_pkg::mcr_mux_conn_t positive_mux_output_out,
   output mcr_pkg::mcr_mux_conn_t negative_mux_output_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Select decode, one connection at most per code

   function automatic mcr_pkg::mcr_mux_conn_t mcr_decode(input logic [4:0] code);
      mcr_pkg::mcr_mux_conn_t conn;
      conn = '0;
      case (code)
         mcr_pkg::MCR_SRC_SECOND_REFERENCE_VOLTAGE_250K: conn.second_reference_voltage_250k = 1'b1;
         mcr_pkg::MCR_SRC_SECOND_REFERENCE_VOLTAGE: conn.second_reference_voltage_direct = 1'b1;
         mcr_pkg::MCR_SRC_CF1_POS: conn.cap_one_positive = 1'b1;
         mcr_pkg::MCR_SRC_CF1_NEG: conn.cap_one_negative = 1'b1;
         mcr_pkg::MCR_SRC_CF2_POS: conn.cap_two_positive = 1'b1;
         mcr_pkg::MCR_SRC_CF2_NEG: conn.cap_two_negative = 1'b1;
         mcr_pkg::MCR_SRC_BAT_POS: conn.battery_positive = 1'b1;
         mcr_pkg::MCR_SRC_BAT_NEG: conn.battery_negative = 1'b1;
         mcr_pkg::MCR_SRC_POS_TEST: conn.pos_test_node = 1'b1;
         mcr_pkg::MCR_SRC_NEG_TEST: conn.neg_test_node = 1'b1;
         default: begin
            // Codes 1..12 are general inputs; reserved and zero connect nothing
            if (code >= mcr_pkg::MCR_SRC_GEN_FIRST && code <= mcr_pkg::MCR_SRC_GEN_LAST) begin
               conn.general[code[3:0] - 4'h1] = 1'b1;
            end
         end
      endcase
      return conn;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register state

   logic [7:0] dead_band_q;
   logic [7:0] timebase_q;
   logic [4:0] mux_pos_q;
   logic [4:0] mux_neg_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path: address and data held until both are present

   logic aw_held_q;
   logic w_held_q;
   logic [`MCR_ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;

   wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
   wire hit_wr_db = aw_addr_q == `MCR_ADDR_OF(`MCR_IDX_DEADBAND);
   wire hit_wr_tb = aw_addr_q == `MCR_ADDR_OF(`MCR_IDX_TIMEBASE);
   wire hit_wr_mp = aw_addr_q == `MCR_ADDR_OF(`MCR_IDX_MUX_POS);
   wire hit_wr_mn = aw_addr_q == `MCR_ADDR_OF(`MCR_IDX_MUX_NEG);
   wire hit_wr_st = aw_addr_q == `MCR_ADDR_OF(`MCR_IDX_STATUS);
   wire wr_mapped = hit_wr_db || hit_wr_tb || hit_wr_mp || hit_wr_mn || hit_wr_st;
   wire wr_lane0 = wr_fire && w_strb_q[0];

   assign s_axi_awready_out = !aw_held_q;
   assign s_axi_wready_out = !w_held_q;
   assign s_axi_bvalid_out = bvalid_q;
   assign s_axi_bresp_out = bresp_q;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in;
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bvalid_q <= 1'b0;
         bresp_q <= `MCR_RESP_OKAY;
      end else if (wr_fire) begin
         // A pending response holds off the next write until bready is seen
         bvalid_q <= 1'b1;
         bresp_q <= wr_mapped ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         bvalid_q <= 1'b0;
      end
   end

   // Only byte lane 0 carries register bits; the upper lanes are ignored
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dead_band_q <= `MCR_RST_DEADBAND;
         timebase_q <= `MCR_RST_TIMEBASE;
         mux_pos_q <= `MCR_RST_MUX;
         mux_neg_q <= `MCR_RST_MUX;
      end else if (wr_lane0) begin
         if (hit_wr_db) dead_band_q <= w_data_q[7:0];
         if (hit_wr_tb) timebase_q <= w_data_q[7:0];
         if (hit_wr_mp) mux_pos_q <= w_data_q[4:0];
         if (hit_wr_mn) mux_neg_q <= w_data_q[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Dead band gated accumulation

   mcr_pkg::mcr_accum_t acc_q;
   logic compare_pending_q;
   logic compare_done_q;
   logic [3:0] above_q;
   logic [3:0] below_q;

   wire [19:0] cur_mag = second_sample_in.current[19] ?
      20'(-second_sample_in.current) : 20'(second_sample_in.current);
   // Most negative sample wraps to itself; read unsigned it is still the full magnitude
   wire pass_band = cur_mag >= {12'h000, dead_band_q};
   wire do_accum = sample_valid_in && pass_band;
   // Combined totals see this channel only; the first channel lies outside the block
   wire signed [47:0] cur_ext = 48'(second_sample_in.current);
   wire signed [47:0] pwr_ext = 48'(second_sample_in.power);

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         acc_q <= '0;
         compare_pending_q <= 1'b0;
      end else begin
         compare_pending_q <= do_accum;
         if (do_accum) begin
            acc_q.charge2 <= acc_q.charge2 + cur_ext;
            acc_q.energy2 <= acc_q.energy2 + pwr_ext;
            acc_q.charge3 <= acc_q.charge3 + cur_ext;
            acc_q.energy4 <= acc_q.energy4 + pwr_ext;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Threshold comparison on the freshly updated values

   // Strict compares: a value equal to its limit raises neither flag
   wire [3:0] above_now = {
      acc_q.energy4 > thresholds_in.high.energy4,
      acc_q.charge3 > thresholds_in.high.charge3,
      acc_q.energy2 > thresholds_in.high.energy2,
      acc_q.charge2 > thresholds_in.high.charge2};
   wire [3:0] below_now = {
      acc_q.energy4 < thresholds_in.low.energy4,
      acc_q.charge3 < thresholds_in.low.charge3,
      acc_q.energy2 < thresholds_in.low.energy2,
      acc_q.charge2 < thresholds_in.low.charge2};

   // Results hold until the next update so skipped samples do not disturb them
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         compare_done_q <= 1'b0;
         above_q <= 4'h0;
         below_q <= 4'h0;
      end else begin
         compare_done_q <= compare_pending_q;
         if (compare_pending_q) begin
            above_q <= above_now;
            below_q <= below_now;
         end
      end
   end

   assign accumulators_out = acc_q;
   assign compare_done_out = compare_done_q;
   assign above_high_out = above_q;
   assign below_low_out = below_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Timebase and multiplexer outputs

   wire [2:0] pre_field = timebase_q[`MCR_PRE_MSB:`MCR_PRE_LSB];
   assign prescaler_out = pre_field;
   assign divider_out = timebase_q[`MCR_DIV_MSB:`MCR_DIV_LSB];
   assign internal_clock_select_out = pre_field == `MCR_PRE_INTERNAL;

   // Decode is combinational so a select change reaches the switches in the same cycle
   assign positive_mux_select_out = mux_pos_q;
   assign negative_mux_select_out = mux_neg_q;
   assign positive_mux_output_out = mcr_decode(mux_pos_q);
   assign negative_mux_output_out = mcr_decode(mux_neg_q);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // Read data is captured at the address edge, so rdata stands until rready
   wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
   wire hit_rd_db = s_axi_araddr_in == `MCR_ADDR_OF(`MCR_IDX_DEADBAND);
   wire hit_rd_tb = s_axi_araddr_in == `MCR_ADDR_OF(`MCR_IDX_TIMEBASE);
   wire hit_rd_mp = s_axi_araddr_in == `MCR_ADDR_OF(`MCR_IDX_MUX_POS);
   wire hit_rd_mn = s_axi_araddr_in == `MCR_ADDR_OF(`MCR_IDX_MUX_NEG);
   wire hit_rd_st = s_axi_araddr_in == `MCR_ADDR_OF(`MCR_IDX_STATUS);
   wire rd_mapped = hit_rd_db || hit_rd_tb || hit_rd_mp || hit_rd_mn || hit_rd_st;
   wire [31:0] status_word = {23'h000000, internal_clock_select_out, below_q, above_q};
   wire [31:0] rd_mux =
      hit_rd_db ? {24'h000000, dead_band_q} :
      hit_rd_tb ? {24'h000000, timebase_q} :
      hit_rd_mp ? {27'h0000000, mux_pos_q} :
      hit_rd_mn ? {27'h0000000, mux_neg_q} :
      hit_rd_st ? status_word : 32'h0000_0000;

   assign s_axi_arready_out = !rvalid_q;
   assign s_axi_rvalid_out = rvalid_q;
   assign s_axi_rdata_out = rdata_q;
   assign s_axi_rresp_out = rresp_q;

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `MCR_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_mapped ? `MCR_RESP_OKAY : `MCR_RESP_SLVERR;
      end else if (s_axi_rready_in) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule

//--- verification/mcr_top_properties.sv
// Checker of mux decode, timebase select and threshold timing of the meter control block
`timescale 1ns/1ps
`include "mcr_regs.svh"

module mcr_top_properties (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // Observed design signals
   input wire mcr_pkg::mcr_thresh_t thresholds_in,
   input wire mcr_pkg::mcr_accum_t accumulators_out,
   input wire logic compare_done_out,
   input wire logic [3:0] above_high_out,
   input wire logic [3:0] below_low_out,
   input wire logic internal_clock_select_out,
   input wire logic [2:0] prescaler_out,
   input wire logic [4:0] positive_mux_select_out,
   input wire logic [4:0] negative_mux_select_out,
   input wire mcr_pkg::mcr_mux_conn_t positive_mux_output_out,
   input wire mcr_pkg::mcr_mux_conn_t negative_mux_output_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // Flags of a against b, bit order charge2, energy2, charge3, energy4
   function automatic logic [3:0] gt4(input mcr_pkg::mcr_accum_t a, input mcr_pkg::mcr_accum_t b);
      return {a.energy4 > b.energy4, a.charge3 > b.charge3, a.energy2 > b.energy2,
         a.charge2 > b.charge2};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   int_clock_sel_a: assert property (
      internal_clock_select_out == (prescaler_out == 3'h7)) else $error("clock select wrong");
   vref_250k_a: assert property (
      positive_mux_select_out == 5'h17 |-> positive_mux_output_out == 22'h000001)
      else $error("code 23 decode wrong");
   vref_direct_a: assert property (
      negative_mux_select_out == 5'h16 |-> negative_mux_output_out == 22'h000002)
      else $error("code 22 decode wrong");
   pos_test_a: assert property (
      positive_mux_select_out == 5'h0E |-> positive_mux_output_out == 22'h000100)
      else $error("code 14 decode wrong");
   neg_test_a: assert property (
      negative_mux_select_out == 5'h0D |-> negative_mux_output_out == 22'h000200)
      else $error("code 13 decode wrong");
   gen_input_a: assert property (
      positive_mux_select_out inside {[5'h01:5'h0C]} |-> positive_mux_output_out ==
      ({12'h001, 10'h000} << (positive_mux_select_out - 5'h01))) else $error("general wrong");
   rsvd_none_a: assert property (
      (positive_mux_select_out[4:3] == 2'h3 || positive_mux_select_out == 5'h15) |->
      positive_mux_output_out == 22'h000000) else $error("reserved code connects");
   update_cmp_a: assert property ($changed(accumulators_out) |=> compare_done_out)
      else $error("no compare after update");
   above_flags_a: assert property (compare_done_out |-> above_high_out ==
      gt4($past(accumulators_out), $past(thresholds_in.high))) else $error("above flags wrong");
   below_flags_a: assert property (compare_done_out |-> below_low_out ==
      gt4($past(thresholds_in.low), $past(accumulators_out))) else $error("below flags wrong");
   cover property (compare_done_out);
   cover property (positive_mux_select_out == 5'h17);
   cover property (!internal_clock_select_out);
endmodule

bind mcr_top mcr_top_properties mcr_top_properties_inst (
   .clock_in(clock_in), .reset_n_in(reset_n_in), .thresholds_in(thresholds_in),
   .accumulators_out(accumulators_out), .compare_done_out(compare_done_out),
   .above_high_out(above_high_out), .below_low_out(below_low_out),
   .internal_clock_select_out(internal_clock_select_out), .prescaler_out(prescaler_out),
   .positive_mux_select_out(positive_mux_select_out),
   .negative_mux_select_out(negative_mux_select_out),
   .positive_mux_output_out(positive_mux_output_out),
   .negative_mux_output_out(negative_mux_output_out)
);

//--- verification/mcr_top_tb.sv
// Self-checking bench of the meter control block over its register bus and sample port
`timescale 1ns/1ps
`include "mcr_regs.svh"
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

module mcr_top_tb;
   logic clock_in = 1'b0, reset_n_in = 1'b0, sample_valid_in = 1'b0;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   logic [11:0] s_axi_awaddr_in = 12'h000, s_axi_araddr_in = 12'h000;
   logic [31:0] s_axi_wdata_in = 32'h00000000;
   logic [3:0] s_axi_wstrb_in = 4'h0;
   mcr_pkg::mcr_sample_t second_sample_in = '0;
   // Thresholds held: high 20, low -5, every quantity
   mcr_pkg::mcr_thresh_t thresholds_in = {{4{48'h000000000014}}, {4{48'hFFFFFFFFFFFB}}};
   logic awready, wready, bvalid, arready, rvalid, done, int_sel;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] above, below;
   logic [2:0] pre;
   logic [4:0] div, psel, nsel;
   mcr_pkg::mcr_mux_conn_t pconn, nconn;
   mcr_pkg::mcr_accum_t acc, exp_acc = '0;
   int mismatches = 0, check_count = 0;
   logic [7:0] dead;
   logic [1:0] resp;
   logic [31:0] data;
   logic [31:0] exp_st;
   logic [7:0] tdb [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   logic signed [19:0] tcur [9] = '{20'sh00010, -20'sh00010, 20'sh0000F, -20'sh0000F,
      -20'sh00028, 20'sh000FF, 20'sh000FE, -20'sh000FF, 20'sh00000};
   logic signed [31:0] tpwr [9] = '{32'sh64, -32'sh12C, 32'sh5, 32'sh9, 32'sh7, 32'sh1,
      32'sh1, 32'sh2, 32'sh3};

   mcr_top mcr_top_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(awready),
      .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_wvalid_in(s_axi_wvalid_in),
      .s_axi_wready_out(wready), .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(s_axi_bready_in), .s_axi_bresp_out(bresp),
      .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(arready),
      .s_axi_araddr_in(s_axi_araddr_in), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .sample_valid_in(sample_valid_in), .second_sample_in(second_sample_in),
      .thresholds_in(thresholds_in), .accumulators_out(acc), .compare_done_out(done),
      .above_high_out(above), .below_low_out(below), .internal_clock_select_out(int_sel),
      .prescaler_out(pre), .divider_out(div), .positive_mux_select_out(psel),
      .negative_mux_select_out(nsel), .positive_mux_output_out(pconn),
      .negative_mux_output_out(nconn));

   initial begin
      forever #20 clock_in = ~clock_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_awaddr_in <= a; s_axi_wdata_in <= d; s_axi_wstrb_in <= s;
      s_axi_awvalid_in <= 1'b1; s_axi_wvalid_in <= 1'b1;
      fork
         begin do @(posedge clock_in); while (awready !== 1'b1); s_axi_awvalid_in <= 1'b0; end
         begin do @(posedge clock_in); while (wready !== 1'b1); s_axi_wvalid_in <= 1'b0; end
      join
      s_axi_bready_in <= 1'b1;
      do @(posedge clock_in); while (bvalid !== 1'b1);
      resp = bresp;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic axi_read(input logic [11:0] a);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      do @(posedge clock_in); while (arready !== 1'b1);
      s_axi_arvalid_in <= 1'b0;
      s_axi_rready_in <= 1'b1;
      do @(posedge clock_in); while (rvalid !== 1'b1);
      data = rdata; resp = rresp;
      s_axi_rready_in <= 1'b0;
   endtask
   // Expected one-hot connection; field order puts general inputs on top
   function automatic mcr_pkg::mcr_mux_conn_t exp_conn(input logic [4:0] c);
      if (c >= 5'h01 && c <= 5'h0C) return 22'h000001 << (c + 9);
      if (c >= 5'h0D && c <= 5'h14) return 22'h000001 << (22 - c);
      if (c == 5'h16 || c == 5'h17) return 22'h000001 << (23 - c);
      return 22'h000000;
   endfunction
   function automatic logic [3:0] gt4(input mcr_pkg::mcr_accum_t a, input mcr_pkg::mcr_accum_t b);
      return {a.energy4 > b.energy4, a.charge3 > b.charge3, a.energy2 > b.energy2,
         a.charge2 > b.charge2};
   endfunction
   task automatic send_sample(input logic signed [19:0] cur, input logic signed [31:0] pwr);
      logic take;
      take = (cur[19] ? -cur : cur) >= {12'h000, dead};
      second_sample_in <= {cur, pwr}; sample_valid_in <= 1'b1;
      @(posedge clock_in);
      sample_valid_in <= 1'b0;
      if (take) begin
         exp_acc.charge2 += cur; exp_acc.energy2 += pwr;
         exp_acc.charge3 += cur; exp_acc.energy4 += pwr;
      end
      @(negedge clock_in);
      `CHK("accumulators", exp_acc, acc)
      @(negedge clock_in);
      `CHK("compare done", take, done)
      `CHK("above flags", gt4(exp_acc, thresholds_in.high), above)
      `CHK("below flags", gt4(thresholds_in.low, exp_acc), below)
      @(posedge clock_in);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clock_in);
      reset_n_in <= 1'b1;
      @(posedge clock_in);
      axi_read(`MCR_ADDR_OF(`MCR_IDX_TIMEBASE));
      `CHK("timebase reset", 32'h00000007, data)
      `CHK("clock select reset", 1'b1, int_sel)
      axi_read(`MCR_ADDR_OF(`MCR_IDX_DEADBAND));
      `CHK("dead band reset", 32'h00000000, data)
      $display("test reset done");
      axi_write(`MCR_ADDR_OF(`MCR_IDX_TIMEBASE), 32'h000000AB, 4'hF);
      `CHK("write resp", `MCR_RESP_OKAY, resp)
      `CHK("prescaler", 3'h3, pre)
      `CHK("divider", 5'h15, div)
      `CHK("clock select ext", 1'b0, int_sel)
      axi_write(`MCR_ADDR_OF(`MCR_IDX_TIMEBASE), 32'h00000007, 4'h0);
      `CHK("strobe off", 3'h3, pre)
      axi_write(`MCR_ADDR_OF(`MCR_IDX_TIMEBASE), 32'h000000FF, 4'hF);
      `CHK("clock select int", 1'b1, int_sel)
      `CHK("divider all ones", 5'h1F, div)
      axi_read(12'h000);
      `CHK("unmapped resp", `MCR_RESP_SLVERR, resp)
      `CHK("unmapped data", 32'h00000000, data)
      axi_write(12'h000, 32'h00000000, 4'hF);
      `CHK("unmapped write resp", `MCR_RESP_SLVERR, resp)
      `CHK("unmapped write effect", 3'h7, pre)
      $display("test timebase done");
      for (int c = 0; c < 32; c++) begin
         axi_write(`MCR_ADDR_OF(`MCR_IDX_MUX_POS), 32'(c), 4'hF);
         axi_write(`MCR_ADDR_OF(`MCR_IDX_MUX_NEG), 32'(31 - c), 4'hF);
         `CHK("positive select", 5'(c), psel)
         `CHK("positive conn", exp_conn(5'(c)), pconn)
         `CHK("negative select", 5'(31 - c), nsel)
         `CHK("negative conn", exp_conn(5'(31 - c)), nconn)
      end
      axi_read(`MCR_ADDR_OF(`MCR_IDX_MUX_POS));
      `CHK("positive readback", 32'h0000001F, data)
      axi_read(`MCR_ADDR_OF(`MCR_IDX_MUX_NEG));
      `CHK("negative readback", 32'h00000000, data)
      $display("test mux done");
      for (int i = 0; i < 9; i++) begin
         axi_write(`MCR_ADDR_OF(`MCR_IDX_DEADBAND), {24'h000000, tdb[i]}, 4'hF);
         dead = tdb[i];
         axi_read(`MCR_ADDR_OF(`MCR_IDX_DEADBAND));
         `CHK("dead band", {24'h000000, tdb[i]}, data)
         send_sample(tcur[i], tpwr[i]);
      end
      exp_st = {23'h000000, 1'b1, gt4(thresholds_in.low, exp_acc),
         gt4(exp_acc, thresholds_in.high)};
      axi_read(`MCR_ADDR_OF(`MCR_IDX_STATUS));
      `CHK("status", exp_st, data)
      $display("test dead band done");
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clock_in);
      mismatches++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule
